/* src/tr_pkg.sv */
// Overview of operation
// - data termination code 000 off, 111 forbidden
// - cmd/addr termination in 6:4, 111 forbidden
// - termination at address 0b, reference 0c
// - writes and reads use write-selected copy
// - outputs follow the operate-selected copy only
// - inactive copy writes leave operation unchanged
// - reference read returns eight bits, reserved zero
// - controller writes levels 000000 to 110010 only
// - bit 6 picks range, range 1 after reset
// - range kept until rewritten or reset
// - range and level go in one write
// - level field resets to 001101
// - reference bit 7 ignored, reads zero
// - grounded calibration pin ignores calibration commands
package tr_pkg;

  // ----------------------------------------------------------------
  // mode register map
  // ----------------------------------------------------------------
  localparam logic [5:0] MA_TERM       = 6'h0b;
  localparam logic [5:0] MA_REF        = 6'h0c;
  localparam int         DQ_TERM_LSB   = 0;
  localparam int         CA_TERM_LSB   = 4;
  localparam int         LEVEL_LSB     = 0;
  localparam int         RANGE_BIT     = 6;
  localparam logic [2:0] TERM_RESERVED = 3'h7;
  localparam logic [2:0] TERM_RST      = 3'h0;
  localparam logic [5:0] LEVEL_MAX     = 6'h32;
  localparam logic [5:0] LEVEL_RST     = 6'h0d;
  localparam logic       RANGE_RST     = 1'b1;
  localparam int         NUM_SP        = 2;
  localparam logic [1:0] STRAP_SETTLE  = 2'h2;

  // ----------------------------------------------------------------
  // controller registers on the host bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_SP     = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int         CMD_OP_LSB  = 0;
  localparam int         CMD_MA_LSB  = 8;
  localparam int         CMD_RD_BIT  = 16;
  localparam int         CMD_CAL_BIT = 17;
  localparam int         SP_WR_BIT   = 0;
  localparam int         SP_OP_BIT   = 1;
  localparam int         ST_BUSY     = 0;
  localparam int         ST_DONE     = 1;
  localparam int         ST_REFUSED  = 2;
  localparam int         ST_DATA_LSB = 8;

  typedef enum logic [0:0] {
    TR_IDLE    = 1'b0,
    TR_WAIT_RD = 1'b1
  } tr_ctl_state_t;

endpackage

/* src/tr_mr_if.sv */
`timescale 1ns/1ns
interface tr_mr_if;
  logic       mrw;
  logic       mrr;
  logic       cal_cmd;
  logic [5:0] ma;
  logic [7:0] op;
  logic       wr_sel;
  logic       op_sel;
  logic [7:0] rd_data;
  logic       rd_valid;

  modport dev (
    input  mrw,
    input  mrr,
    input  cal_cmd,
    input  ma,
    input  op,
    input  wr_sel,
    input  op_sel,
    output rd_data,
    output rd_valid
  );

  modport ctl (
    output mrw,
    output mrr,
    output cal_cmd,
    output ma,
    output op,
    output wr_sel,
    output op_sel,
    input  rd_data,
    input  rd_valid
  );
endinterface

/* src/tr_device.sv */
`timescale 1ns/1ns
module tr_device (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  tr_mr_if.dev            mr,
  input  wire logic       cal_pin_gnd,
  output logic [2:0]      data_termination_field,
  output logic [2:0]      cmd_addr_termination_field,
  output logic [5:0]      ca_ref_level,
  output logic            ca_ref_range,
  output logic            cal_default,
  output logic            cal_start
);

  // ----------------------------------------------------------------
  // per set point storage
  // ----------------------------------------------------------------
  logic [2:0] dq_term_r   [tr_pkg::NUM_SP];
  logic [2:0] dq_term_nxt [tr_pkg::NUM_SP];
  logic [2:0] ca_term_r   [tr_pkg::NUM_SP];
  logic [2:0] ca_term_nxt [tr_pkg::NUM_SP];
  logic [5:0] level_r     [tr_pkg::NUM_SP];
  logic [5:0] level_nxt   [tr_pkg::NUM_SP];
  logic       range_r     [tr_pkg::NUM_SP];
  logic       range_nxt   [tr_pkg::NUM_SP];

  logic [2:0] op_dq;
  logic [2:0] op_ca;

  assign op_dq = mr.op[tr_pkg::DQ_TERM_LSB +: 3];
  assign op_ca = mr.op[tr_pkg::CA_TERM_LSB +: 3];

  genvar sp;
  generate
    for (sp = 0; sp < tr_pkg::NUM_SP; sp++) begin : g_sp
      logic hit;

      // only the copy picked by the write select takes the write
      assign hit = mr.mrw && (mr.wr_sel == 1'(sp));

      always_comb begin
        dq_term_nxt[sp] = dq_term_r[sp];
        ca_term_nxt[sp] = ca_term_r[sp];
        level_nxt[sp]   = level_r[sp];
        range_nxt[sp]   = range_r[sp];
        if (hit && mr.ma == tr_pkg::MA_TERM) begin
          // a forbidden code would leave the receiver undefined, so keep the old one
          if (op_dq != tr_pkg::TERM_RESERVED) begin
            dq_term_nxt[sp] = op_dq;
          end
          if (op_ca != tr_pkg::TERM_RESERVED) begin
            ca_term_nxt[sp] = op_ca;
          end
        end
        if (hit && mr.ma == tr_pkg::MA_REF) begin
          // bit 7 has no storage on this width
          level_nxt[sp] = mr.op[tr_pkg::LEVEL_LSB +: 6];
          range_nxt[sp] = mr.op[tr_pkg::RANGE_BIT];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dq_term_r[sp] <= tr_pkg::TERM_RST;
          ca_term_r[sp] <= tr_pkg::TERM_RST;
          level_r[sp]   <= tr_pkg::LEVEL_RST;
          range_r[sp]   <= tr_pkg::RANGE_RST;
        end else begin
          dq_term_r[sp] <= dq_term_nxt[sp];
          ca_term_r[sp] <= ca_term_nxt[sp];
          level_r[sp]   <= level_nxt[sp];
          range_r[sp]   <= range_nxt[sp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // operating copy
  // ----------------------------------------------------------------
  logic [2:0] act_dq_r;
  logic [2:0] act_dq_nxt;
  logic [2:0] act_ca_r;
  logic [2:0] act_ca_nxt;
  logic [5:0] act_level_r;
  logic [5:0] act_level_nxt;
  logic       act_range_r;
  logic       act_range_nxt;

  // the other copy is never looked at, so writing it cannot disturb operation
  always_comb begin
    act_dq_nxt    = dq_term_r[mr.op_sel];
    act_ca_nxt    = ca_term_r[mr.op_sel];
    act_level_nxt = level_r[mr.op_sel];
    act_range_nxt = range_r[mr.op_sel];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_dq_r    <= tr_pkg::TERM_RST;
      act_ca_r    <= tr_pkg::TERM_RST;
      act_level_r <= tr_pkg::LEVEL_RST;
      act_range_r <= tr_pkg::RANGE_RST;
    end else begin
      act_dq_r    <= act_dq_nxt;
      act_ca_r    <= act_ca_nxt;
      act_level_r <= act_level_nxt;
      act_range_r <= act_range_nxt;
    end
  end

  assign data_termination_field     = act_dq_r;
  assign cmd_addr_termination_field = act_ca_r;
  assign ca_ref_level               = act_level_r;
  assign ca_ref_range               = act_range_r;

  // ----------------------------------------------------------------
  // mode register read
  // ----------------------------------------------------------------
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;

  // termination register is write-only and answers zero like every address except the reference at 0c
  always_comb begin
    rd_data_nxt  = 8'h00;
    rd_valid_nxt = mr.mrr;
    if (mr.mrr && mr.ma == tr_pkg::MA_REF) begin
      rd_data_nxt = {1'b0, range_r[mr.wr_sel], level_r[mr.wr_sel]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign mr.rd_data  = rd_data_r;
  assign mr.rd_valid = rd_valid_r;

  // ----------------------------------------------------------------
  // calibration strap
  // ----------------------------------------------------------------
  logic       pin_meta_r;
  logic       pin_sync_r;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic       cal_def_r;
  logic       cal_def_nxt;
  logic       cal_start_r;
  logic       cal_start_nxt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= cal_pin_gnd;
      pin_sync_r <= pin_meta_r;
    end
  end

  // the strap may not change after power-up; it is checked every cycle once
  // the synchroniser has settled, until a low pin clears default calibration, which is assumed till then
  always_comb begin
    settle_nxt    = settle_r;
    cal_def_nxt   = cal_def_r;
    cal_start_nxt = 1'b0;
    if (settle_r != tr_pkg::STRAP_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
    end else if (settle_r == tr_pkg::STRAP_SETTLE && cal_def_r && !pin_sync_r) begin
      cal_def_nxt = 1'b0;
    end
    if (mr.cal_cmd && !cal_def_r) begin
      cal_start_nxt = 1'b1;
    end
  end

  // strap level is latched one-way: a later rise on the synced pin is ignored
  // only because cal_def_r cannot return to one outside reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_r    <= 2'h0;
      cal_def_r   <= 1'b1;
      cal_start_r <= 1'b0;
    end else begin
      settle_r    <= settle_nxt;
      cal_def_r   <= cal_def_nxt;
      cal_start_r <= cal_start_nxt;
    end
  end

  assign cal_default = cal_def_r;
  assign cal_start   = cal_start_r;

endmodule

/* src/tr_ctl.sv */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
module tr_ctl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  tr_mr_if.ctl             mr
);

  // ----------------------------------------------------------------
  // bus slave, zero wait states
  // ----------------------------------------------------------------
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        take;
  logic [31:0] status;

  logic [1:0]  sp_r;
  logic [1:0]  sp_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        refused_r;
  logic        refused_nxt;
  logic [7:0]  rdat_r;
  logic [7:0]  rdat_nxt;
  tr_pkg::tr_ctl_state_t st_r;
  tr_pkg::tr_ctl_state_t st_nxt;

  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_comb begin
    status = 32'h0;
    status[tr_pkg::ST_BUSY]                 = (st_r != tr_pkg::TR_IDLE);
    status[tr_pkg::ST_DONE]                 = done_r;
    status[tr_pkg::ST_REFUSED]              = refused_r;
    status[tr_pkg::ST_DATA_LSB +: 8]        = rdat_r;
  end

  // read data is loaded at the address phase so it stands in the data phase
  always_comb begin
    wr_pend_nxt = take && hwrite;
    wr_addr_nxt = take ? haddr[7:0] : wr_addr_r;
    hrdata_nxt  = 32'h0;
    if (take && !hwrite) begin
      case (haddr[7:0])
        tr_pkg::ADDR_SP:     hrdata_nxt = {30'h0, sp_r};
        tr_pkg::ADDR_STATUS: hrdata_nxt = status;
        default:             hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // command issue
  // ----------------------------------------------------------------
  logic       mrw_r;
  logic       mrw_nxt;
  logic       mrr_r;
  logic       mrr_nxt;
  logic       cal_r;
  logic       cal_nxt;
  logic [5:0] ma_r;
  logic [5:0] ma_nxt;
  logic [7:0] op_r;
  logic [7:0] op_nxt;
  logic       cmd_wr;
  logic [5:0] c_ma;
  logic [7:0] c_op;
  logic       bad;

  assign cmd_wr = wr_pend_r && wr_addr_r == tr_pkg::ADDR_CMD;
  assign c_ma   = hwdata[tr_pkg::CMD_MA_LSB +: 6];
  // range and level travel in the one op byte, never split over two writes
  assign c_op   = hwdata[tr_pkg::CMD_OP_LSB +: 8];

  // forbidden codes never reach the memory
  always_comb begin
    bad = 1'b0;
    if (!hwdata[tr_pkg::CMD_RD_BIT] && !hwdata[tr_pkg::CMD_CAL_BIT]) begin
      if (c_ma == tr_pkg::MA_TERM) begin
        bad = c_op[tr_pkg::DQ_TERM_LSB +: 3] == tr_pkg::TERM_RESERVED
           || c_op[tr_pkg::CA_TERM_LSB +: 3] == tr_pkg::TERM_RESERVED;
      end else if (c_ma == tr_pkg::MA_REF) begin
        bad = c_op[tr_pkg::LEVEL_LSB +: 6] > tr_pkg::LEVEL_MAX;
      end
    end
  end

  always_comb begin
    st_nxt      = st_r;
    mrw_nxt     = 1'b0;
    mrr_nxt     = 1'b0;
    cal_nxt     = 1'b0;
    ma_nxt      = ma_r;
    op_nxt      = op_r;
    sp_nxt      = sp_r;
    rdat_nxt    = rdat_r;
    done_nxt    = done_r;
    refused_nxt = refused_r;
    if (wr_pend_r && wr_addr_r == tr_pkg::ADDR_SP) begin
      sp_nxt = {hwdata[tr_pkg::SP_OP_BIT], hwdata[tr_pkg::SP_WR_BIT]};
    end
    // clear first so that a same-cycle event below wins
    if (wr_pend_r && wr_addr_r == tr_pkg::ADDR_STATUS) begin
      if (hwdata[tr_pkg::ST_DONE]) begin
        done_nxt = 1'b0;
      end
      if (hwdata[tr_pkg::ST_REFUSED]) begin
        refused_nxt = 1'b0;
      end
    end
    case (st_r)
      tr_pkg::TR_IDLE: begin
        if (cmd_wr && bad) begin
          refused_nxt = 1'b1;
        end else if (cmd_wr) begin
          ma_nxt = c_ma;
          op_nxt = c_op;
          if (hwdata[tr_pkg::CMD_CAL_BIT]) begin
            cal_nxt  = 1'b1;
            done_nxt = 1'b1;
          end else if (hwdata[tr_pkg::CMD_RD_BIT]) begin
            mrr_nxt = 1'b1;
            st_nxt  = tr_pkg::TR_WAIT_RD;
          end else begin
            mrw_nxt  = 1'b1;
            done_nxt = 1'b1;
          end
        end
      end
      tr_pkg::TR_WAIT_RD: begin
        if (cmd_wr) begin
          refused_nxt = 1'b1;
        end
        if (mr.rd_valid) begin
          rdat_nxt = mr.rd_data;
          done_nxt = 1'b1;
          st_nxt   = tr_pkg::TR_IDLE;
        end
      end
      default: st_nxt = tr_pkg::TR_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= tr_pkg::TR_IDLE;
      mrw_r     <= 1'b0;
      mrr_r     <= 1'b0;
      cal_r     <= 1'b0;
      ma_r      <= 6'h00;
      op_r      <= 8'h00;
      sp_r      <= 2'h0;
      rdat_r    <= 8'h00;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      mrw_r     <= mrw_nxt;
      mrr_r     <= mrr_nxt;
      cal_r     <= cal_nxt;
      ma_r      <= ma_nxt;
      op_r      <= op_nxt;
      sp_r      <= sp_nxt;
      rdat_r    <= rdat_nxt;
      done_r    <= done_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign mr.mrw     = mrw_r;
  assign mr.mrr     = mrr_r;
  assign mr.cal_cmd = cal_r;
  assign mr.ma      = ma_r;
  assign mr.op      = op_r;
  assign mr.wr_sel  = sp_r[tr_pkg::SP_WR_BIT];
  assign mr.op_sel  = sp_r[tr_pkg::SP_OP_BIT];

endmodule

/* test/tr_link_properties.sv */
`timescale 1ns/1ns
module tr_link_properties (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       mrw,
  input wire logic       mrr,
  input wire logic [5:0] ma,
  input wire logic [7:0] op,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // mode register traffic
  // ----------------------------------------------------------------
  sequence s_read_ref;
    mrr && ma == tr_pkg::MA_REF;
  endsequence
  sequence s_read_term;
    mrr && ma == tr_pkg::MA_TERM;
  endsequence
  sequence s_write_term;
    mrw && ma == tr_pkg::MA_TERM;
  endsequence

  property p_read_answer;
    mrr |=> rd_valid;
  endproperty
  property p_valid_cause;
    rd_valid |-> $past(mrr);
  endproperty
  property p_idle_zero;
    !rd_valid |-> rd_data == 8'h00;
  endproperty
  property p_ref_rsv;
    s_read_ref |=> rd_valid && rd_data[7] == 1'b0;
  endproperty
  property p_term_wo;
    s_read_term |=> rd_valid && rd_data == 8'h00;
  endproperty
  property p_dq_code;
    s_write_term |-> op[2:0] != tr_pkg::TERM_RESERVED;
  endproperty
  property p_ca_code;
    s_write_term |-> op[6:4] != tr_pkg::TERM_RESERVED;
  endproperty
  property p_level_max;
    mrw && ma == tr_pkg::MA_REF |-> op[5:0] <= tr_pkg::LEVEL_MAX;
  endproperty

  a_read_answer: assert property (p_read_answer)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (p_valid_cause)
    else $error("answer without read");
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero when idle");
  a_ref_rsv: assert property (p_ref_rsv)
    else $error("reserved reference bit read as one");
  a_term_wo: assert property (p_term_wo)
    else $error("termination read not zero");
  a_dq_code: assert property (p_dq_code)
    else $error("reserved data termination code issued");
  a_ca_code: assert property (p_ca_code)
    else $error("reserved cmd termination code issued");
  a_level_max: assert property (p_level_max)
    else $error("reserved level code issued");
endmodule

/* test/termination_and_ca_reference_regs_tb.sv */
`timescale 1ns/1ns
module termination_and_ca_reference_regs_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        cal_pin_gnd = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  dq;
  logic [2:0]  ca;
  logic [5:0]  lvl;
  logic        rng;
  logic        cal_def;
  logic        cal_start;
  int          bad_count = 0;
  int          checked = 0;
  int          cal_seen = 0;

  always #4 hclk = ~hclk;
  always @(posedge hclk) if (cal_start === 1'b1) cal_seen++;

  tr_mr_if mr_link ();
  tr_ctl i_tr_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mr(mr_link));
  tr_device i_tr_device (.hclk(hclk), .hresetn(hresetn), .mr(mr_link),
    .cal_pin_gnd(cal_pin_gnd), .data_termination_field(dq), .cmd_addr_termination_field(ca),
    .ca_ref_level(lvl), .ca_ref_range(rng), .cal_default(cal_def), .cal_start(cal_start));
  tr_link_properties i_tr_link_properties (.hclk(hclk), .hresetn(hresetn),
    .mrw(mr_link.mrw), .mrr(mr_link.mrr), .ma(mr_link.ma), .op(mr_link.op),
    .rd_data(mr_link.rd_data), .rd_valid(mr_link.rd_valid));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up;
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) give_up();
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  // poll until done or refused; busy must be gone first
  task automatic mr_cmd(input logic rd, input logic [5:0] a, input logic [7:0] d,
                        output logic [31:0] st);
    logic [31:0] q;
    int          n;
    bus(1'b1, tr_pkg::ADDR_CMD, {15'h0, rd, 2'h0, a, d}, q);
    n = 0;
    do begin
      bus(1'b0, tr_pkg::ADDR_STATUS, 32'h0, st);
      n++;
    end while ((st[0] !== 1'b0 || st[2:1] == 2'h0) && n < 16);
    if (st[0] !== 1'b0 || st[2:1] == 2'h0) give_up();
    bus(1'b1, tr_pkg::ADDR_STATUS, 32'h6, q);
  endtask

  task automatic rd_mr(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] st;
    mr_cmd(1'b1, a, 8'h00, st);
    chk({24'h0, st[15:8]}, {24'h0, e});
  endtask

  task automatic outs(input logic [2:0] e_dq, input logic [2:0] e_ca,
                      input logic [5:0] e_lvl, input logic e_rng);
    chk({19'h0, dq, ca, lvl, rng}, {19'h0, e_dq, e_ca, e_lvl, e_rng});
  endtask

  task automatic sp(input logic wr, input logic opn);
    logic [31:0] q;
    bus(1'b1, tr_pkg::ADDR_SP, {30'h0, opn, wr}, q);
    bus(1'b0, tr_pkg::ADDR_SP, 32'h0, q);
    chk(q, {30'h0, opn, wr});
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // window of eight cycles, far longer than the one-cycle answer
  task automatic cal_try(input int e);
    logic [31:0] q;
    cal_seen = 0;
    bus(1'b1, tr_pkg::ADDR_CMD, 32'h20000, q);
    repeat (8) @(posedge hclk);
    chk(32'(cal_seen), 32'(e));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    outs(3'h0, 3'h0, tr_pkg::LEVEL_RST, tr_pkg::RANGE_RST);
    bus(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rd_mr(tr_pkg::MA_REF, 8'h4d);
  endtask

  task automatic t_term;
    logic [31:0] q;
    for (int c = 0; c < 7; c++) begin
      mr_cmd(1'b0, tr_pkg::MA_TERM, {1'b0, 3'(6 - c), 1'b0, 3'(c)}, q);
      outs(3'(c), 3'(6 - c), tr_pkg::LEVEL_RST, 1'b1);
    end
    mr_cmd(1'b0, tr_pkg::MA_TERM, 8'h27, q);
    chk({31'h0, q[2]}, 32'h1);
    mr_cmd(1'b0, tr_pkg::MA_TERM, 8'h71, q);
    chk({31'h0, q[2]}, 32'h1);
    outs(3'h6, 3'h0, tr_pkg::LEVEL_RST, 1'b1);
    rd_mr(tr_pkg::MA_TERM, 8'h00);
  endtask

  task automatic t_ref;
    logic [31:0] q;
    mr_cmd(1'b0, tr_pkg::MA_REF, 8'hb2, q);
    outs(3'h6, 3'h0, 6'h32, 1'b0);
    rd_mr(tr_pkg::MA_REF, 8'h32);
    mr_cmd(1'b0, tr_pkg::MA_REF, 8'h33, q);
    chk({31'h0, q[2]}, 32'h1);
    mr_cmd(1'b0, tr_pkg::MA_TERM, 8'h00, q);
    outs(3'h0, 3'h0, 6'h32, 1'b0);
  endtask

  task automatic t_sp;
    logic [31:0] q;
    sp(1'b1, 1'b0);
    mr_cmd(1'b0, tr_pkg::MA_REF, 8'h45, q);
    mr_cmd(1'b0, tr_pkg::MA_TERM, 8'h12, q);
    outs(3'h0, 3'h0, 6'h32, 1'b0);
    rd_mr(tr_pkg::MA_REF, 8'h45);
    sp(1'b0, 1'b0);
    rd_mr(tr_pkg::MA_REF, 8'h32);
    sp(1'b0, 1'b1);
    outs(3'h2, 3'h1, 6'h05, 1'b1);
  endtask

  task automatic t_cal;
    chk({31'h0, cal_def}, 32'h0);
    cal_try(1);
    cal_pin_gnd <= 1'b1;
    do_reset();
    repeat (8) @(posedge hclk);
    outs(3'h0, 3'h0, tr_pkg::LEVEL_RST, tr_pkg::RANGE_RST);
    chk({31'h0, cal_def}, 32'h1);
    cal_try(0);
  endtask

  initial begin
    do_reset();
    t_reset();
    t_term();
    t_ref();
    t_sp();
    t_cal();
    tally_and_finish();
  end
endmodule
